// [hw/gpm_ivl_timer.sv]
// Millisecond interval timer for the duty-cycled power-save mode.
// Assumes a start pulse from the same clock domain; done pulses once per interval.
`timescale 1ns/100ps
`default_nettype none
module gpm_ivl_timer #(
  parameter int unsigned CYC_PER_MS = 40000
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic [5:0] ms_i,
  output logic            done_o
);

  localparam logic [31:0] LAST_CYC = 32'(CYC_PER_MS - 1);

  logic [31:0] cyc_r;
  logic [5:0]  ms_r;
  logic        run_r;

  // ==========================================================================
  // Counting
  // A new start reloads even while running, so a restart never leaks a stale done
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cyc_r  <= '0;
      ms_r   <= '0;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cyc_r <= '0;
        ms_r  <= ms_i;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cyc_r == LAST_CYC) begin
          cyc_r <= '0;
          if (ms_r == 6'd1) begin
            run_r  <= 1'b0;
            done_o <= 1'b1;
          end else begin
            ms_r <= ms_r - 6'd1;
          end
        end else begin
          cyc_r <= cyc_r + 32'd1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hw/gpm_pkg.sv]
// Package for the rate-sensor power-mode controller.
// Shared register offsets, field positions, reset values, mode types and interval tables.
package gpm_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned ONE_MS_US   = 1000;
  localparam int unsigned CYC_PER_MS  = (CLK_FREQ_HZ / 1_000_000) * ONE_MS_US;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_BW       = 8'h10;
  localparam logic [7:0] ADDR_LPM1     = 8'h11;
  localparam logic [7:0] ADDR_LPM2     = 8'h12;
  localparam logic [7:0] ADDR_RESTART  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CFG  = 8'h20;
  localparam logic [7:0] ADDR_BUS_CFG  = 8'h34;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_SUSPEND   = 7;
  localparam int unsigned BIT_DEEP      = 5;
  localparam int unsigned POS_DOZE      = 1;
  localparam int unsigned BIT_FAST_PU   = 7;
  localparam int unsigned BIT_PWR_SAVE  = 6;
  localparam int unsigned POS_TRIG_SEL  = 4;
  localparam int unsigned POS_AWAKE     = 0;
  localparam int unsigned BIT_A_LVL     = 0;
  localparam int unsigned BIT_A_OD      = 1;
  localparam int unsigned BIT_B_LVL     = 2;
  localparam int unsigned BIT_B_OD      = 3;
  localparam int unsigned BIT_SER3      = 0;
  localparam int unsigned BIT_WDT_SEL   = 1;
  localparam int unsigned BIT_WDT_EN    = 2;
  localparam int unsigned POS_BW        = 0;

  // ==========================================================================
  // Reset values
  localparam logic [3:0] RST_BW    = 4'h0;
  localparam logic [2:0] RST_DOZE  = 3'h0;
  localparam logic [2:0] RST_AWAKE = 3'h0;
  localparam logic [1:0] RST_TRIG  = 2'h0;

  // Wake-trigger source codes
  localparam logic [1:0] TRIG_NONE = 2'h0;
  localparam logic [1:0] TRIG_AUXA = 2'h1;
  localparam logic [1:0] TRIG_AUXB = 2'h2;
  localparam logic [1:0] TRIG_SDO  = 2'h3;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_DEEP_SUSPEND, MODE_SUSPEND, MODE_FAST_PU} gpm_mode_e;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } gpm_wr_s;

  typedef struct packed {
    logic sampling_en;
    logic sense_on;
    logic drive_on;
    logic digital_on;
  } gpm_pwr_s;

  typedef struct packed {
    logic irq_pin_a_active_level;
    logic irq_pin_a_open_drain;
    logic irq_pin_b_active_level;
    logic irq_pin_b_open_drain;
  } gpm_irqcfg_s;

  // Doze interval code to milliseconds
  function automatic logic [5:0] gpm_doze_ms(input logic [2:0] code);
    case (code)
      3'h0:    gpm_doze_ms = 6'd2;
      3'h1:    gpm_doze_ms = 6'd4;
      3'h2:    gpm_doze_ms = 6'd5;
      3'h3:    gpm_doze_ms = 6'd8;
      3'h4:    gpm_doze_ms = 6'd10;
      3'h5:    gpm_doze_ms = 6'd15;
      3'h6:    gpm_doze_ms = 6'd18;
      default: gpm_doze_ms = 6'd20;
    endcase
  endfunction

  // Awake interval code to milliseconds; forbidden code 0 runs as the shortest
  function automatic logic [5:0] gpm_awake_ms(input logic [2:0] code);
    case (code)
      3'h2:    gpm_awake_ms = 6'd5;
      3'h3:    gpm_awake_ms = 6'd8;
      3'h4:    gpm_awake_ms = 6'd10;
      3'h5:    gpm_awake_ms = 6'd15;
      3'h6:    gpm_awake_ms = 6'd20;
      3'h7:    gpm_awake_ms = 6'd40;
      default: gpm_awake_ms = 6'd4;
    endcase
  endfunction

  function automatic gpm_pwr_s gpm_pwr_of(input gpm_mode_e m);
    case (m)
      MODE_NORMAL:       gpm_pwr_of = '{1'b1, 1'b1, 1'b1, 1'b1};
      MODE_FAST_PU:      gpm_pwr_of = '{1'b0, 1'b0, 1'b1, 1'b1};
      MODE_SUSPEND:      gpm_pwr_of = '{1'b0, 1'b0, 1'b0, 1'b1};
      default:           gpm_pwr_of = '{1'b0, 1'b0, 1'b0, 1'b0};
    endcase
  endfunction

endpackage

// [hw/gpm_power_ctrl.sv]
// Power-mode controller of the rate-sensing section of a motion sensor.
// Assumes register writes arrive as single-cycle strobes on clk_i; wake pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module gpm_power_ctrl
  import gpm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS_P = CYC_PER_MS
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire gpm_wr_s     wr_i,
  input  wire logic        aux_irq_pin_first_i,
  input  wire logic        aux_irq_pin_second_i,
  input  wire logic        rate_serial_data_out_pin_i,
  output gpm_mode_e        mode_o,
  output gpm_pwr_s         pwr_o,
  output logic [3:0]       filter_bandwidth_code_o,
  output logic             three_wire_serial_select_o,
  output logic             bus_wdt_en_o,
  output logic             bus_wdt_period_sel_o,
  output gpm_irqcfg_s      irq_cfg_o,
  output logic             wr_refused_o,
  output logic             wake_o
);

  logic        deep_r, deep_nxt;
  logic        susp_r, susp_nxt;
  logic        fpu_r, fpu_nxt;
  logic        psave_r, psave_nxt;
  logic [2:0]  doze_r, doze_nxt;
  logic [2:0]  awake_r, awake_nxt;
  logic [3:0]  bw_r, bw_nxt;
  logic [1:0]  trig_r;
  logic        ps_doze_r, ps_run_r;
  logic        ivl_done, ivl_start;
  logic        accept, restart, wake;
  logic [2:0]  pin_s1_r, pin_s2_r, pin_prev_r;
  logic        trig_edge;
  gpm_mode_e   mode_nxt;

  // ==========================================================================
  // Write acceptance
  // suspend filter
  always_comb begin
    case (mode_o)
      MODE_SUSPEND:      accept = (wr_i.addr == ADDR_RESTART);
      MODE_DEEP_SUSPEND: accept = (wr_i.addr == ADDR_LPM1) || (wr_i.addr == ADDR_BUS_CFG) ||
                                  (wr_i.addr == ADDR_IRQ_CFG) || (wr_i.addr == ADDR_RESTART);
      default:           accept = 1'b1;
    endcase
  end

  assign restart = wr_i.en && (wr_i.addr == ADDR_RESTART);

  // ==========================================================================
  // Wake pins: two-stage sync, then edge on the settled stage only
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_s1_r   <= {rate_serial_data_out_pin_i, aux_irq_pin_second_i, aux_irq_pin_first_i};
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  always_comb begin
    case (trig_r)
      TRIG_AUXA: trig_edge = pin_s2_r[0] & ~pin_prev_r[0];
      TRIG_AUXB: trig_edge = pin_s2_r[1] & ~pin_prev_r[1];
      TRIG_SDO:  trig_edge = three_wire_serial_select_o & pin_s2_r[2] & ~pin_prev_r[2];
      default:   trig_edge = 1'b0;
    endcase
  end

  assign wake = trig_edge && ((mode_o == MODE_SUSPEND) || (mode_o == MODE_DEEP_SUSPEND));

  // ==========================================================================
  // Mode control bits
  always_comb begin
    deep_nxt  = deep_r;
    susp_nxt  = susp_r;
    fpu_nxt   = fpu_r;
    psave_nxt = psave_r;
    doze_nxt  = doze_r;
    awake_nxt = awake_r;
    bw_nxt    = bw_r;
    if (wr_i.en && accept) begin
      if (wr_i.addr == ADDR_LPM1) begin
        deep_nxt = wr_i.data[BIT_DEEP];
        if (mode_o != MODE_DEEP_SUSPEND) begin
          susp_nxt = wr_i.data[BIT_SUSPEND];
          doze_nxt = wr_i.data[POS_DOZE +: 3];
        end
      end
      if (wr_i.addr == ADDR_LPM2) begin
        fpu_nxt   = wr_i.data[BIT_FAST_PU];
        psave_nxt = wr_i.data[BIT_PWR_SAVE];
        awake_nxt = wr_i.data[POS_AWAKE +: 3];
      end
      if (wr_i.addr == ADDR_BW) begin
        bw_nxt = wr_i.data[POS_BW +: 4];
      end
    end
    if (wake || restart) begin
      deep_nxt = 1'b0;
      susp_nxt = 1'b0;
    end
    // configuration lost on deep entry
    // Deep entry never meets wake or restart: both need another address or mode
    if ((deep_nxt && !deep_r) || restart) begin
      susp_nxt  = 1'b0;
      fpu_nxt   = 1'b0;
      psave_nxt = 1'b0;
      doze_nxt  = RST_DOZE;
      awake_nxt = RST_AWAKE;
      bw_nxt    = RST_BW;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      deep_r  <= 1'b0;
      susp_r  <= 1'b0;
      fpu_r   <= 1'b0;
      psave_r <= 1'b0;
      doze_r  <= RST_DOZE;
      awake_r <= RST_AWAKE;
      bw_r    <= RST_BW;
    end else begin
      deep_r  <= deep_nxt;
      susp_r  <= susp_nxt;
      fpu_r   <= fpu_nxt;
      psave_r <= psave_nxt;
      doze_r  <= doze_nxt;
      awake_r <= awake_nxt;
      bw_r    <= bw_nxt;
    end
  end

  // ==========================================================================
  // Settings that survive deep suspend
  // three-wire select, watchdog, interrupt-pin and wake-trigger controls
  always_ff @(posedge clk_i) begin
    if (!resetn_i || restart) begin
      three_wire_serial_select_o <= 1'b0;
      bus_wdt_en_o               <= 1'b0;
      bus_wdt_period_sel_o       <= 1'b0;
      irq_cfg_o                  <= '0;
      trig_r                     <= RST_TRIG;
    end else if (wr_i.en && accept) begin
      if (wr_i.addr == ADDR_BUS_CFG) begin
        three_wire_serial_select_o <= wr_i.data[BIT_SER3];
        bus_wdt_en_o               <= wr_i.data[BIT_WDT_EN];
        bus_wdt_period_sel_o       <= wr_i.data[BIT_WDT_SEL];
      end
      if (wr_i.addr == ADDR_IRQ_CFG) begin
        irq_cfg_o <= '{wr_i.data[BIT_A_LVL], wr_i.data[BIT_A_OD], wr_i.data[BIT_B_LVL], wr_i.data[BIT_B_OD]};
      end
      if (wr_i.addr == ADDR_LPM2) begin
        trig_r <= wr_i.data[POS_TRIG_SEL +: 2];
      end
    end
  end

  // ==========================================================================
  // Duty cycling
  // alternate normal and fast power-up
  // Only runs while no sleep request is pending
  assign ivl_start = (psave_r && !deep_r && !susp_r) && (!ps_run_r || ivl_done);

  always_ff @(posedge clk_i) begin
    if (!resetn_i || !psave_r || deep_r || susp_r) begin
      ps_run_r  <= 1'b0;
      ps_doze_r <= 1'b0;
    end else if (ivl_start) begin
      ps_run_r  <= 1'b1;
      ps_doze_r <= ps_run_r && !ps_doze_r;
    end
  end

  gpm_ivl_timer #(.CYC_PER_MS(CYC_PER_MS_P)) u_ivl (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (ivl_start),
    .ms_i     ((ps_run_r && !ps_doze_r) ? gpm_doze_ms(doze_r) : gpm_awake_ms(awake_r)),
    .done_o   (ivl_done)
  );

  // ==========================================================================
  // Mode decode
  // single decoded mode
  always_comb begin
    if (deep_nxt) begin
      mode_nxt = MODE_DEEP_SUSPEND;
    end else if (susp_nxt && !fpu_nxt) begin
      mode_nxt = MODE_SUSPEND;
    end else if (susp_nxt || (ps_doze_r && psave_nxt)) begin
      mode_nxt = MODE_FAST_PU;
    end else begin
      mode_nxt = MODE_NORMAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mode_o       <= MODE_NORMAL;
      pwr_o        <= gpm_pwr_of(MODE_NORMAL);
      wr_refused_o <= 1'b0;
      wake_o       <= 1'b0;
    end else begin
      mode_o       <= mode_nxt;
      pwr_o        <= gpm_pwr_of(mode_nxt);
      wr_refused_o <= wr_i.en && !accept;
      wake_o       <= wake;
    end
  end

  assign filter_bandwidth_code_o = bw_r;
  // ==========================================================================
  // Checks
  sequence s_deep_req;
    wr_i.en && accept && !restart && (wr_i.addr == ADDR_LPM1) && wr_i.data[BIT_DEEP] && !wake;
  endsequence
  sequence s_deep_bus_wr;
    (mode_o == MODE_DEEP_SUSPEND) && wr_i.en && (wr_i.addr == ADDR_BUS_CFG);
  endsequence

  AST_NORMAL_SAMPLES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == MODE_NORMAL) |-> (pwr_o.sampling_en && pwr_o.sense_on))
    else $error("normal mode without sampling");
  AST_DEEP_ENTER: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_deep_req |=> (mode_o == MODE_DEEP_SUSPEND) && !pwr_o.digital_on)
    else $error("deep request not honoured");
  AST_DEEP_LOSES_CFG: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (s_deep_req and (mode_o != MODE_DEEP_SUSPEND)) |=> (filter_bandwidth_code_o == RST_BW) && !psave_r)
    else $error("configuration kept across deep entry");
  AST_DEEP_WDT_LIVE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    s_deep_bus_wr |=> (bus_wdt_en_o == $past(wr_i.data[BIT_WDT_EN])))
    else $error("watchdog enable not writable in deep suspend");
  AST_RESTART_NORMAL: assert property (@(posedge clk_i) disable iff (!resetn_i)
    restart |=> (mode_o == MODE_NORMAL) ##1 (mode_o == MODE_NORMAL) || psave_r || susp_r || deep_r)
    else $error("soft restart did not return to normal");
  AST_SUSPEND_REFUSES: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == MODE_SUSPEND) && wr_i.en && (wr_i.addr == ADDR_BW) |=> wr_refused_o && $stable(filter_bandwidth_code_o))
    else $error("write accepted in suspend");
  AST_FAST_PU_ENTER: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (mode_o == MODE_NORMAL) && fpu_r && wr_i.en && (wr_i.addr == ADDR_LPM1) && wr_i.data[BIT_SUSPEND] &&
    !wr_i.data[BIT_DEEP] |=> (mode_o == MODE_FAST_PU) && pwr_o.drive_on && !pwr_o.sense_on)
    else $error("fast power-up not entered");
  AST_WAKE_TO_NORMAL: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake && !wr_i.en |=> wake_o && (mode_o != MODE_SUSPEND) && (mode_o != MODE_DEEP_SUSPEND))
    else $error("wake trigger ignored");
  // Enable may drop on the very edge that starts the doze phase, so look one cycle back
  AST_DUTY_NEEDS_ENABLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(ps_doze_r) |-> $past(psave_r) && $past(ivl_done))
    else $error("doze phase without duty-cycle enable");

endmodule
`default_nettype wire

// [tb/gpm_host_model.sv]
// Host-side model of the power-mode block: single-byte register writes and wake pins.
// Assumes the block's clock; every change lands 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module gpm_host_model
  import gpm_pkg::*;
#(
  parameter int unsigned GAP_CYC = 2
) (
  input  wire logic  clk_i,
  output gpm_wr_s    wr_o,
  output logic [2:0] pins_o
);
  // ==========================================================================
  // State
  logic [3:0] bw_r = 4'h0;

  initial begin
    wr_o   = '{1'b0, 8'hFF, 8'hFF};
    pins_o = 3'h0;
  end

  // ==========================================================================
  // Awake floor
  // floor on awake only
  function automatic logic [2:0] min_awake(input logic [3:0] bw);
    case (bw)
      4'h7, 4'h5: min_awake = 3'h6;
      4'h6, 4'h4: min_awake = 3'h4;
      4'h3:       min_awake = 3'h2;
      default:    min_awake = 3'h1;
    endcase
  endfunction

  // ==========================================================================
  // Write and pin tasks
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dd;
    dd = d;
    // no code 000, none below floor
    if (a == ADDR_LPM2 && dd[2:0] < min_awake(bw_r)) dd[2:0] = min_awake(bw_r);
    if (a == ADDR_BW) bw_r = dd[3:0];
    @(posedge clk_i);
    #1 wr_o = '{1'b1, a, dd};
    @(posedge clk_i);
    // Released lines show the inverse, never stale data
    #1 wr_o = '{1'b0, ~a, ~dd};
    repeat (GAP_CYC) @(posedge clk_i);
    #1;
  endtask

  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_i);
    #1 pins_o[idx] = v;
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench of the power-mode block: mode entry, refusal, wake and duty cycle.
// Assumes the host model as the only writer; ms counts shortened to 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import gpm_pkg::*;
();
  // ==========================================================================
  // Signals
  localparam int CPM = 4;
  logic        clk_i;
  logic        resetn_i;
  gpm_wr_s     wr;
  logic [2:0]  pins;
  gpm_mode_e   mode;
  gpm_pwr_s    pwr;
  logic [3:0]  bw;
  logic        ser;
  logic        wen;
  logic        wsel;
  gpm_irqcfg_s irq;
  logic        refused;
  logic        wake;
  int          bad_count = 0;
  int          n_checks = 0;
  int          ref_cnt = 0;
  int          wake_cnt = 0;
  int          cyc = 0;
  int          i;
  int          k;
  int          w0;
  int          doze_tab[8] = '{2, 4, 5, 8, 10, 15, 18, 20};
  int          awk_tab[8] = '{4, 4, 5, 8, 10, 15, 20, 40};

  gpm_power_ctrl #(.CYC_PER_MS_P(CPM)) uut (
    .clk_i                      (clk_i),
    .resetn_i                   (resetn_i),
    .wr_i                       (wr),
    .aux_irq_pin_first_i        (pins[0]),
    .aux_irq_pin_second_i       (pins[1]),
    .rate_serial_data_out_pin_i (pins[2]),
    .mode_o                     (mode),
    .pwr_o                      (pwr),
    .filter_bandwidth_code_o    (bw),
    .three_wire_serial_select_o (ser),
    .bus_wdt_en_o               (wen),
    .bus_wdt_period_sel_o       (wsel),
    .irq_cfg_o                  (irq),
    .wr_refused_o               (refused),
    .wake_o                     (wake)
  );

  gpm_host_model host (
    .clk_i  (clk_i),
    .wr_o   (wr),
    .pins_o (pins)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Pulse counters and hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (refused === 1'b1) ref_cnt <= ref_cnt + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 30000) begin
      chk(1'b0, 1'b1);
      end_of_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_mode(input gpm_mode_e m);
    logic [3:0] p;
    case (m)
      MODE_NORMAL:  p = 4'hF;
      MODE_FAST_PU: p = 4'h3;
      MODE_SUSPEND: p = 4'h1;
      default:      p = 4'h0;
    endcase
    chk(mode, m);
    chk(pwr, p);
  endtask

  task automatic chk_cfg(input logic [10:0] e);
    chk({bw, ser, wen, wsel, irq}, e);
  endtask

  task automatic wr1(input logic [7:0] a, input logic [7:0] d, input int exp_ref);
    int c0;
    c0 = ref_cnt;
    host.write(a, d);
    chk(ref_cnt - c0, exp_ref);
  endtask

  task automatic measure(input int ef, input int en);
    int f;
    int n;
    int r;
    for (n = 0; n < 400 && mode !== MODE_FAST_PU; n++) begin
      @(posedge clk_i);
      #1;
    end
    for (r = 0; r < 2; r++) begin
      f = 0;
      n = 0;
      while (mode === MODE_FAST_PU && f < 200) begin
        @(posedge clk_i);
        #1 f++;
      end
      while (mode === MODE_NORMAL && n < 400) begin
        @(posedge clk_i);
        #1 n++;
      end
      chk(f >= ef && f <= ef + 2, 1'b1);
      chk(n >= en && n <= en + 2, 1'b1);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    resetn_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    chk_mode(MODE_NORMAL);
    chk_cfg(11'h000);
    wr1(ADDR_BW, 8'h03, 0);
    wr1(ADDR_IRQ_CFG, 8'h0F, 0);
    wr1(ADDR_BUS_CFG, 8'h07, 0);
    chk_cfg({4'h3, 3'h7, 4'hF});
    wr1(ADDR_LPM1, 8'h20, 0);
    chk_mode(MODE_DEEP_SUSPEND);
    chk_cfg({4'h0, 3'h7, 4'hF});
    wr1(ADDR_BW, 8'h09, 1);
    wr1(ADDR_BUS_CFG, 8'h02, 0);
    wr1(ADDR_IRQ_CFG, 8'h01, 0);
    chk_cfg({4'h0, 3'h1, 4'h8});
    wr1(ADDR_LPM1, 8'h00, 0);
    chk_mode(MODE_NORMAL);
    wr1(ADDR_BW, 8'h05, 0);
    wr1(ADDR_LPM1, 8'h20, 0);
    wr1(ADDR_RESTART, 8'h5A, 0);
    chk_mode(MODE_NORMAL);
    chk_cfg(11'h000);
    wr1(ADDR_BW, 8'h05, 0);
    wr1(ADDR_LPM1, 8'h80, 0);
    chk_mode(MODE_SUSPEND);
    wr1(ADDR_IRQ_CFG, 8'h0F, 1);
    wr1(ADDR_BW, 8'h07, 1);
    chk_cfg({4'h5, 3'h0, 4'h0});
    wr1(ADDR_RESTART, 8'h00, 0);
    chk_mode(MODE_NORMAL);
    // Wrong pin first, then the selected one
    for (i = 1; i <= 3; i++) begin
      wr1(ADDR_BUS_CFG, (i == 3) ? 8'h01 : 8'h00, 0);
      wr1(ADDR_LPM2, 8'(i << 4), 0);
      wr1(ADDR_LPM1, (i == 2) ? 8'h20 : 8'h80, 0);
      w0 = wake_cnt;
      host.set_pin(i % 3, 1'b1);
      repeat (8) @(posedge clk_i);
      #1;
      chk(wake_cnt - w0, 0);
      chk_mode((i == 2) ? MODE_DEEP_SUSPEND : MODE_SUSPEND);
      host.set_pin(i % 3, 1'b0);
      host.set_pin(i - 1, 1'b1);
      for (k = 0; k < 8 && wake_cnt == w0; k++) begin
        @(posedge clk_i);
        #1;
      end
      chk(wake_cnt - w0, 1);
      chk_mode(MODE_NORMAL);
      host.set_pin(i - 1, 1'b0);
    end
    wr1(ADDR_LPM2, 8'h80, 0);
    wr1(ADDR_LPM1, 8'h80, 0);
    chk_mode(MODE_FAST_PU);
    wr1(ADDR_BW, 8'h02, 0);
    chk(bw, 4'h2);
    wr1(ADDR_LPM1, 8'h00, 0);
    chk_mode(MODE_NORMAL);
    // Every doze code, awake codes 1 to 7
    for (i = 0; i < 8; i++) begin
      wr1(ADDR_LPM2, 8'h00, 0);
      wr1(ADDR_LPM1, 8'(i << 1), 0);
      wr1(ADDR_LPM2, 8'h40 | 8'((i == 0) ? 1 : i), 0);
      measure(doze_tab[i] * CPM, awk_tab[i] * CPM);
    end
    wr1(ADDR_LPM2, 8'h00, 0);
    chk_mode(MODE_NORMAL);
    wr1(ADDR_BW, 8'h07, 0);
    @(posedge clk_i);
    #1 resetn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    chk_mode(MODE_NORMAL);
    chk_cfg(11'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
